// >>> verilog/hm_pkg.sv
// Constants, carrier types and states for the two-wire display host
package hm_pkg;
  // Clock and bus timing
  localparam int CLK_NS = 50;
  localparam int QTR_NS = 625;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUS_FREE_NS = 1300;
  localparam int FREE_CYC = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [7:0] FREE_LAST = 8'(FREE_CYC - 1);

  // Address byte layout and byte framing
  localparam logic [5:0] ADDR_HI = 6'h1c;
  localparam logic [7:0] RESYNC_BYTE = 8'h00;
  localparam logic [3:0] BIT_FIRST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h0;

  // One byte offered by the user side
  typedef struct packed {
    logic [7:0] data;
    logic cmd_last;
    logic xfer_last;
  } hm_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BUSFREE,
    ST_START,
    ST_BIT,
    ST_LOAD,
    ST_STOP
  } hm_state_t;
endpackage

// >>> verilog/hm_i2c_host.sv
// Two-wire bus master that writes commands and data to the display driver
// Behaviour
// - Bus idle means both lines high
// - Master starts only on an idle bus
// - SDA falling with SCL high is START
// - SDA rising with SCL high is STOP
// - SDA stays steady while SCL is high
// - Unlimited bytes between START and STOP
// - Eight bits then one acknowledge pulse
// - Master always sends write bit zero
// - Transfer opens with START then address
// - Command MSB flags more commands follow
// - After reset send START, zero, STOP
`timescale 1ns/1ps
`default_nettype none
module hm_i2c_host
(
  input wire logic sys_clk_in, // 20 MHz system clock
  input wire logic resetn_in, // Async reset, active low
  input wire logic address_select_pin_in, // Level strapped on target
  input wire hm_pkg::hm_byte_t byte_in, // Byte with framing flags
  input wire logic byte_valid_in, // Byte offered
  output logic byte_ready_out, // Byte taken this cycle
  output logic busy_out, // Transfer in progress
  output logic done_out, // Transfer finished, pulse
  output logic nack_out, // Transfer refused, pulse
  input wire logic scl_in, // Clock line level
  output logic scl_out, // Clock line drive value
  output logic scl_oe_n_out, // Clock line pulled low when 0
  input wire logic sda_in, // Data line level
  output logic sda_out, // Data line drive value
  output logic sda_oe_n_out // Data line pulled low when 0
);
  import hm_pkg::*;

  hm_state_t state_reg;
  logic scl_m_reg;
  logic scl_s_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  logic sel_m_reg;
  logic sel_s_reg;
  logic [7:0] cnt_reg;
  logic [1:0] qtr_reg;
  logic [3:0] bit_idx_reg;
  logic [7:0] tx_byte_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic init_pend_reg;
  logic first_reg;
  logic cmd_phase_reg;
  logic cur_cmd_reg;
  logic cur_last_cmd_reg;
  logic last_reg;
  logic nack_seen_reg;
  logic done_reg;
  logic nack_reg;
  logic bus_idle;
  logic stalled;
  logic qtr_end;

  // Pins come from another domain: two flops before any use
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sel_m_reg <= 1'b0;
      sel_s_reg <= 1'b0;
    end
    else
    begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      // Strap is a pin too; a slow edge must not split the address byte
      sel_m_reg <= address_select_pin_in;
      sel_s_reg <= sel_m_reg;
    end
  end

  // Idle bus and clock stretching; high quarters wait for SCL to rise
  assign bus_idle = sda_s_reg && scl_s_reg;
  assign stalled = qtr_reg[1] && !scl_s_reg;
  assign qtr_end = (cnt_reg == QTR_LAST) && !stalled;

  // Sequencer for START, bits, acknowledge slots and STOP
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      qtr_reg <= 2'h0;
      bit_idx_reg <= 4'h0;
      tx_byte_reg <= 8'h00;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      init_pend_reg <= 1'b1;
      first_reg <= 1'b0;
      cmd_phase_reg <= 1'b0;
      cur_cmd_reg <= 1'b0;
      cur_last_cmd_reg <= 1'b0;
      last_reg <= 1'b0;
      nack_seen_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= 8'h00;
          qtr_reg <= 2'h0;
          nack_seen_reg <= 1'b0;
          // Resync transfer always goes first after reset
          if (init_pend_reg || byte_valid_in)
            state_reg <= ST_BUSFREE;
        end
        ST_BUSFREE:
        begin
          // Another master's traffic restarts the idle count
          if (!bus_idle)
            cnt_reg <= 8'h00;
          else if (cnt_reg == FREE_LAST)
          begin
            cnt_reg <= 8'h00;
            sda_oe_n_reg <= 1'b0;
            state_reg <= ST_START;
          end
          else
            cnt_reg <= 8'(cnt_reg + 8'h01);
        end
        ST_START:
        begin
          if (cnt_reg == QTR_LAST)
          begin
            cnt_reg <= 8'h00;
            qtr_reg <= 2'(qtr_reg + 2'h1);
            if (qtr_reg == 2'h1)
            begin
              // Address byte right after START, or the zero byte while resync is pending; write bit zero
              scl_oe_n_reg <= 1'b0;
              qtr_reg <= 2'h0;
              bit_idx_reg <= BIT_FIRST;
              tx_byte_reg <= init_pend_reg ? RESYNC_BYTE :
                {ADDR_HI, sel_s_reg, 1'b0};
              first_reg <= 1'b1;
              last_reg <= 1'b0;
              cmd_phase_reg <= !init_pend_reg;
              cur_cmd_reg <= 1'b0;
              state_reg <= ST_BIT;
            end
          end
          else
            cnt_reg <= 8'(cnt_reg + 8'h01);
        end
        ST_BIT:
        begin
          if (qtr_end)
          begin
            cnt_reg <= 8'h00;
            qtr_reg <= 2'(qtr_reg + 2'h1);
            unique case (qtr_reg)
              // Data changes only a quarter into the low phase
              2'h0: sda_oe_n_reg <= (bit_idx_reg == BIT_ACK) ? 1'b1 :
                tx_byte_reg[3'(bit_idx_reg - 4'h1)];
              2'h1: scl_oe_n_reg <= 1'b1;
              2'h2: scl_oe_n_reg <= 1'b1;
              2'h3:
              begin
                scl_oe_n_reg <= 1'b0;
                if (bit_idx_reg != BIT_ACK)
                  bit_idx_reg <= 4'(bit_idx_reg - 4'h1);
                else if (!init_pend_reg && sda_s_reg)
                begin
                  // Released line in the slot: target did not answer
                  nack_seen_reg <= 1'b1;
                  state_reg <= ST_STOP;
                end
                else if (init_pend_reg || last_reg)
                  state_reg <= ST_STOP;
                else
                  state_reg <= ST_LOAD;
              end
            endcase
          end
          else if (!stalled)
            cnt_reg <= 8'(cnt_reg + 8'h01);
        end
        ST_LOAD:
        begin
          // SCL held low while waiting, so a slow source only stretches
          if (byte_valid_in)
          begin
            tx_byte_reg <= cmd_phase_reg ?
              {!byte_in.cmd_last, byte_in.data[6:0]} : byte_in.data;
            if (byte_in.cmd_last)
              cmd_phase_reg <= 1'b0;
            cur_cmd_reg <= cmd_phase_reg;
            cur_last_cmd_reg <= byte_in.cmd_last;
            last_reg <= byte_in.xfer_last;
            first_reg <= 1'b0;
            bit_idx_reg <= BIT_FIRST;
            state_reg <= ST_BIT;
          end
        end
        ST_STOP:
        begin
          if (qtr_end)
          begin
            cnt_reg <= 8'h00;
            qtr_reg <= 2'(qtr_reg + 2'h1);
            unique case (qtr_reg)
              2'h0: sda_oe_n_reg <= 1'b0;
              2'h1: scl_oe_n_reg <= 1'b1;
              2'h2: scl_oe_n_reg <= 1'b1;
              2'h3:
              begin
                sda_oe_n_reg <= 1'b1;
                init_pend_reg <= 1'b0;
                done_reg <= 1'b1;
                nack_reg <= nack_seen_reg;
                state_reg <= ST_IDLE;
              end
            endcase
          end
          else if (!stalled)
            cnt_reg <= 8'(cnt_reg + 8'h01);
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Open-drain drive: value is always low, enables carry the level
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = scl_oe_n_reg;
  assign sda_oe_n_out = sda_oe_n_reg;
  assign byte_ready_out = (state_reg == ST_LOAD) && byte_valid_in;
  assign busy_out = (state_reg != ST_IDLE);
  assign done_out = done_reg;
  assign nack_out = nack_reg;

  // Checks on the line sequencing
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_start_only: assert property (
    ($fell(sda_oe_n_reg) && scl_oe_n_reg) |-> state_reg == ST_START)
    else $error("data pulled low with clock high outside start");

  a_stop_ends: assert property (
    ($rose(sda_oe_n_reg) && scl_oe_n_reg) |-> done_out)
    else $error("data released with clock high outside stop");

  a_sda_stable: assert property (
    (state_reg == ST_BIT && scl_oe_n_reg && $past(scl_oe_n_reg))
    |-> $stable(sda_oe_n_reg))
    else $error("data changed while clock released");

  a_bus_free: assert property (
    (state_reg == ST_START && $past(state_reg) == ST_BUSFREE)
    |-> $past(bus_idle))
    else $error("start issued on a busy bus");

  a_free_wait: assert property (
    (state_reg == ST_BUSFREE && !bus_idle) |=> state_reg != ST_START)
    else $error("start followed busy bus too soon");

  a_ack_release: assert property (
    (state_reg == ST_BIT && bit_idx_reg == BIT_ACK && qtr_reg[1])
    |-> sda_oe_n_reg)
    else $error("master drove data in acknowledge slot");

  a_ninth_pulse: assert property (
    $rose(state_reg == ST_LOAD) |-> $past(bit_idx_reg) == BIT_ACK)
    else $error("byte ended before acknowledge pulse");

  a_addr_write: assert property (
    (state_reg == ST_BIT && first_reg && !init_pend_reg)
    |-> tx_byte_reg == {ADDR_HI, sel_s_reg, 1'b0})
    else $error("address byte wrong or not a write");

  a_resync_zero: assert property (
    (state_reg == ST_BIT && first_reg && init_pend_reg)
    |-> tx_byte_reg == RESYNC_BYTE)
    else $error("first transfer after reset not zero byte");

  a_cmd_flag: assert property (
    (state_reg == ST_BIT && !first_reg && cur_cmd_reg)
    |-> tx_byte_reg[7] == !cur_last_cmd_reg)
    else $error("continuation flag wrong on command byte");

  c_resync: cover property (done_out && init_pend_reg == 1'b0 && !nack_out);
  c_nack: cover property (nack_out);
  c_multi: cover property (state_reg == ST_LOAD && !first_reg);
  c_stretch: cover property (state_reg == ST_BIT && stalled);
endmodule
`default_nettype wire

// >>> dv/hm_lcd_model.sv
// Behavioural display driver slave on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module hm_lcd_model
(
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  input wire logic sel_in, // Strap level of this slave
  input wire logic slow_in, // Stretch clock after each ack
  output logic sda_pull_out, // Pull data line low
  output logic scl_hold_out // Hold clock line low
);
  logic [7:0] sh;
  logic [7:0] rx_q[$];
  int bitc = 0;
  logic act = 0;
  logic addr_ph = 0;
  logic st = 0;
  initial
  begin
    sda_pull_out = 0;
    scl_hold_out = 0;
  end
  // START aborts any byte and restarts address reception
  always @(negedge sda_in)
    if (scl_in)
    begin
      act = 1;
      addr_ph = 1;
      bitc = 0;
    end
  // STOP returns to idle
  always @(posedge sda_in)
    if (scl_in)
      act = 0;
  // Bits are taken on the rising clock, MSB first
  always @(posedge scl_in)
    if (act && bitc < 8)
    begin
      sh = {sh[6:0], sda_in};
      bitc++;
    end
  // Ack decision after the eighth bit, release after the ninth
  always @(negedge scl_in)
    if (act && bitc == 8)
    begin
      bitc = 9;
      if (addr_ph && sh != {6'h1c, sel_in, 1'b0})
        act = 0;
      else
      begin
        if (!addr_ph)
          rx_q.push_back(sh);
        addr_ph = 0;
        sda_pull_out = 1;
      end
    end
    else if (bitc == 9)
    begin
      // Only a slave that answered may stretch; an ignored one keeps off
      if (sda_pull_out)
        st = ~st;
      sda_pull_out = 0;
      bitc = 0;
    end
  // Slow answer: clock held low after each ack
  always @(st)
    if (slow_in)
    begin
      scl_hold_out = 1;
      #2000;
      scl_hold_out = 0;
    end
endmodule
`default_nettype wire

// >>> dv/hm_i2c_host_tb.sv
// Self-checking bench for the two-wire display host
`timescale 1ns/1ps
`default_nettype none
module hm_i2c_host_tb;
  import hm_pkg::*;
  logic clk, rstn, sel, m_sel, slow, valid, ready, busy, done, nack;
  logic scl_oe_n, sda_oe_n, pull, hold, seen_done, seen_nack;
  logic scl_o, sda_o;
  hm_byte_t bin;
  int mismatches, check_count, starts, stops, taken;
  // Pull-ups: a line is low only while someone pulls it
  wire scl_w = (scl_oe_n | scl_o) & ~hold;
  wire sda_w = (sda_oe_n | sda_o) & ~pull;
  hm_i2c_host dut (.sys_clk_in(clk), .resetn_in(rstn),
    .address_select_pin_in(sel), .byte_in(bin), .byte_valid_in(valid),
    .byte_ready_out(ready), .busy_out(busy), .done_out(done),
    .nack_out(nack), .scl_in(scl_w), .scl_out(scl_o),
    .scl_oe_n_out(scl_oe_n), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_n_out(sda_oe_n));
  hm_lcd_model model (.scl_in(scl_w), .sda_in(sda_w), .sel_in(m_sel),
    .slow_in(slow), .sda_pull_out(pull), .scl_hold_out(hold));
  // Wire monitor: an SDA change in a high phase shows as extra events
  always @(negedge sda_w) if (scl_w) starts++;
  always @(posedge sda_w) if (scl_w) stops++;
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Bounded wait for a byte take or the end of the transfer
  task automatic wait_ev(input logic want_ready);
    int n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!(want_ready && ready === 1'b1) && done !== 1'b1 && n < 40000);
    if (n >= 40000)
    begin
      mismatches++;
      $display("[ERR] handshake expected event seen timeout");
      summarize();
    end
    else
    begin
      seen_done = done;
      seen_nack = nack;
    end
  endtask
  // One whole transfer; valid stays up between back-to-back bytes
  task automatic send(input hm_byte_t b[$], input int gap, input logic nk);
    int s0 = starts;
    int p0 = stops;
    taken = 0;
    valid = (b.size() > 0);
    foreach (b[i])
    begin
      bin = b[i];
      wait_ev(1);
      if (seen_done)
        break;
      taken++;
      @(posedge clk);
      #1;
      if (i == 0 && gap > 0)
      begin
        valid = 0;
        repeat (gap) @(posedge clk);
        #1;
        chk("scl during stall", 8'h00, 8'(scl_w));
        valid = 1;
      end
    end
    // An empty list never raised valid, so leave it alone then
    if (b.size() > 0)
      valid = 0;
    if (!seen_done)
      wait_ev(0);
    chk("busy at done", 8'h00, 8'(busy));
    chk("nack", 8'(nk), 8'(seen_nack));
    chk("start count", 8'h01, 8'(starts - s0));
    chk("stop count", 8'h01, 8'(stops - p0));
  endtask
  task automatic chk_rx(input logic [7:0] e[$]);
    chk("rx count", 8'(e.size()), 8'(model.rx_q.size()));
    foreach (e[i])
      chk("rx byte", e[i], model.rx_q[i]);
    model.rx_q.delete();
  endtask
  task automatic t_resync();
    hm_byte_t b[$];
    logic [7:0] e[$];
    @(posedge clk);
    @(negedge clk);
    chk("busy after reset", 8'h01, 8'(busy));
    send(b, 0, 1'b0);
    chk_rx(e);
  endtask
  task automatic t_write(input logic s, input logic sl, input int gap);
    hm_byte_t b[$];
    logic [7:0] e[$];
    b = '{{8'h05, 2'b00}, {8'h83, 2'b10}, {8'h81, 2'b00}, {8'h42, 2'b01}};
    e = '{8'h85, 8'h03, 8'h81, 8'h42};
    @(posedge clk);
    #1;
    sel = s;
    m_sel = s;
    slow = sl;
    send(b, gap, 1'b0);
    chk_rx(e);
  endtask
  task automatic t_refuse();
    hm_byte_t b[$];
    logic [7:0] e[$];
    b = '{{8'h11, 2'b11}};
    @(posedge clk);
    #1;
    sel = 1;
    m_sel = 0;
    send(b, 0, 1'b1);
    chk("bytes taken", 8'h00, 8'(taken));
    chk_rx(e);
  endtask
  initial
  begin
    rstn = 0;
    sel = 0;
    m_sel = 0;
    slow = 0;
    valid = 0;
    bin = '0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1;
    t_resync();
    t_write(1'b0, 1'b0, 0);
    t_write(1'b1, 1'b1, 700);
    t_refuse();
    summarize();
  end
endmodule
`default_nettype wire
